// ---- tcs_defines.svh ----
// Constants for the timer count clock select block
`ifndef TCS_DEFINES_SVH
`define TCS_DEFINES_SVH

// ==========================================================
// Prescaler geometry
`define TCS_DIV_W 12
`define TCS_DIV_RST 12'h000
`define TCS_CHANNELS 6

// ==========================================================
// Tap bit of the prescaler for each division, square-wave midpoint
`define TCS_TAP_DIV4 4'h1
`define TCS_TAP_DIV16 4'h3
`define TCS_TAP_DIV64 4'h5
`define TCS_TAP_DIV256 4'h7
`define TCS_TAP_DIV1024 4'h9
`define TCS_TAP_DIV4096 4'hb

// ==========================================================
// Prescale codes
`define TCS_CODE_0 3'h0
`define TCS_CODE_1 3'h1
`define TCS_CODE_2 3'h2
`define TCS_CODE_3 3'h3
`define TCS_CODE_4 3'h4
`define TCS_CODE_5 3'h5
`define TCS_CODE_6 3'h6
`define TCS_CODE_7 3'h7

// ==========================================================
// Channels able to phase count, one bit per channel
`define TCS_PHASE_CAPABLE 6'h36

`endif

// ---- tcs_pkg.sv ----
// Types for the timer count clock select block
`default_nettype none

package tcs_pkg;

	// ==========================================================
	// Per-channel clock selection fields
	typedef struct packed {
		logic edge_select_hi;
		logic edge_select_lo;
		logic prescale_select_b2;
		logic prescale_select_b1;
		logic prescale_select_b0;
	} tcs_chan_cfg_t;

	// ==========================================================
	// External count pins, sampled as a group
	typedef struct packed {
		logic ext_count_in_d;
		logic ext_count_in_c;
		logic ext_count_in_b;
		logic ext_count_in_a;
	} tcs_ext_pins_t;

	// ==========================================================
	// Count source kinds
	typedef enum logic [3:0] {
		TCS_SRC_DIV1 = 4'h0,
		TCS_SRC_DIV4 = 4'h1,
		TCS_SRC_DIV16 = 4'h2,
		TCS_SRC_DIV64 = 4'h3,
		TCS_SRC_DIV256 = 4'h4,
		TCS_SRC_DIV1024 = 4'h5,
		TCS_SRC_DIV4096 = 4'h6,
		TCS_SRC_EXT_A = 4'h7,
		TCS_SRC_EXT_B = 4'h8,
		TCS_SRC_EXT_C = 4'h9,
		TCS_SRC_EXT_D = 4'ha,
		TCS_SRC_CASCADE = 4'hb
	} tcs_src_t;

endpackage

`default_nettype wire

// ---- tcs_clock_select.sv ----
// Count source and edge selection for six timer channels
`include "tcs_defines.svh"
`default_nettype none

// Function
// - Edge code 00: internal clock counts falling, external pin counts rising.
// - Edge code 01: internal clock counts rising, external pin counts falling.
// - Upper edge bit set: count both edges; lower edge bit ignored.
// - Channel 0 codes 000-011 select divide by 1, 4, 16, 64.
// - Channel 0 codes 100-111 select external inputs A, B, C, D.
// - Channel 1 code 110 divides by 256; 111 counts channel 2 overflow/underflow.
// - Channel 1 codes 000, 001, 011 divide by 1, 4, 64; 100, 101 inputs A, B.
// - Channels 1, 2, 4, 5 ignore prescale selection in phase counting mode.
// - Channel 2: 000-011 divide 1-64, 100-110 inputs A-C, 111 divide 1024.
// - Channel 3: 000-011 divide 1-64, 100 input A, 101-111 divide 1024, 256, 4096.
// - Channel 4: 000, 001 divide 1, 4; 100, 101 inputs A, C; 111 channel 5 cascade.
// - Channel 5: 000-011 divide 1-64, 100, 101 inputs A, C, 110 /256, 111 input D.
// - Internal edge choice applies only at divide 4 or slower, never for cascade.
// - Phase counting mode overrides the edge selection.
module tcs_clock_select import tcs_pkg::*; (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire tcs_chan_cfg_t chan_cfg [`TCS_CHANNELS],
	input wire logic [`TCS_CHANNELS-1:0] phase_mode,
	input wire tcs_ext_pins_t ext_pins,
	input wire logic chan2_counter_wrap,
	input wire logic chan5_counter_wrap,
	output logic [`TCS_CHANNELS-1:0] count_tick
);

	// ==========================================================
	// Source decode per channel
	function automatic tcs_src_t src_decode(input logic [2:0] ch, input logic [2:0] code);
		tcs_src_t s;
		s = TCS_SRC_DIV1;
		unique case (code)
			`TCS_CODE_0: s = TCS_SRC_DIV1;
			`TCS_CODE_1: s = TCS_SRC_DIV4;
			`TCS_CODE_2: s = TCS_SRC_DIV16;
			`TCS_CODE_3: s = TCS_SRC_DIV64;
			`TCS_CODE_4: s = TCS_SRC_EXT_A;
			`TCS_CODE_5: begin
				if (ch == 3'h3) begin
					s = TCS_SRC_DIV1024;
				end else if (ch == 3'h4 || ch == 3'h5) begin
					s = TCS_SRC_EXT_C;
				end else begin
					s = TCS_SRC_EXT_B;
				end
			end
			`TCS_CODE_6: begin
				if (ch == 3'h0 || ch == 3'h2) begin
					s = TCS_SRC_EXT_C;
				end else if (ch == 3'h4) begin
					s = TCS_SRC_DIV1024;
				end else begin
					s = TCS_SRC_DIV256;
				end
			end
			`TCS_CODE_7: begin
				unique case (ch)
					3'h0: s = TCS_SRC_EXT_D;
					3'h1: s = TCS_SRC_CASCADE;
					3'h2: s = TCS_SRC_DIV1024;
					3'h3: s = TCS_SRC_DIV4096;
					3'h4: s = TCS_SRC_CASCADE;
					default: s = TCS_SRC_EXT_D;
				endcase
			end
		endcase
		return s;
	endfunction

	// Prescaler bit that forms the divided square wave
	function automatic logic [3:0] tap_index(input tcs_src_t s);
		logic [3:0] t;
		t = `TCS_TAP_DIV4;
		case (s)
			TCS_SRC_DIV16: t = `TCS_TAP_DIV16;
			TCS_SRC_DIV64: t = `TCS_TAP_DIV64;
			TCS_SRC_DIV256: t = `TCS_TAP_DIV256;
			TCS_SRC_DIV1024: t = `TCS_TAP_DIV1024;
			TCS_SRC_DIV4096: t = `TCS_TAP_DIV4096;
			default: t = `TCS_TAP_DIV4;
		endcase
		return t;
	endfunction

	// Edge choice; internal and external senses are opposite for the same code
	function automatic logic edge_pick(input logic rise, input logic fall, input tcs_chan_cfg_t c,
		input logic internal);
		logic hit;
		if (c.edge_select_hi) begin
			hit = rise | fall;
		end else if (internal) begin
			hit = c.edge_select_lo ? rise : fall;
		end else begin
			hit = c.edge_select_lo ? fall : rise;
		end
		return hit;
	endfunction

	// Edge helpers, shared by pin history and prescaler taps
	function automatic logic rise_of(input logic cur, input logic prev);
		return cur & ~prev;
	endfunction

	function automatic logic fall_of(input logic cur, input logic prev);
		return ~cur & prev;
	endfunction

	// Only channels with a phase counter may be silenced
	localparam logic [`TCS_CHANNELS-1:0] PHASE_CAP = `TCS_PHASE_CAPABLE;

	// ==========================================================
	// State
	logic [`TCS_DIV_W-1:0] div_r;
	logic [`TCS_DIV_W-1:0] div_nxt;
	logic [`TCS_DIV_W-1:0] div_prev_r;
	logic [`TCS_DIV_W-1:0] div_prev_nxt;
	logic [3:0] ext_r;
	logic [3:0] ext_nxt;
	logic [3:0] ext_prev_r;
	logic [3:0] ext_prev_nxt;
	logic [`TCS_CHANNELS-1:0] tick_r;
	logic [`TCS_CHANNELS-1:0] tick_nxt;
	tcs_src_t src_sel [`TCS_CHANNELS];

	// ==========================================================
	// Free-running prescaler, cleared only by reset, so all channels share one phase
	always_comb begin
		div_nxt = div_r + `TCS_DIV_W'(1);
		div_prev_nxt = div_r;
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			div_r <= `TCS_DIV_RST;
			div_prev_r <= `TCS_DIV_RST;
		end else begin
			div_r <= div_nxt;
			div_prev_r <= div_prev_nxt;
		end
	end

	// ==========================================================
	// Pin history; a pin edge costs two cycles of latency
	always_comb begin
		ext_nxt = ext_pins;
		ext_prev_nxt = ext_r;
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ext_r <= 4'h0;
			ext_prev_r <= 4'h0;
		end else begin
			ext_r <= ext_nxt;
			ext_prev_r <= ext_prev_nxt;
		end
	end

	// ==========================================================
	// Source chosen by each channel's prescale field
	always_comb begin
		for (int ch = 0; ch < `TCS_CHANNELS; ch++) begin
			src_sel[ch] = src_decode(3'(ch), {chan_cfg[ch].prescale_select_b2, chan_cfg[ch].prescale_select_b1,
				chan_cfg[ch].prescale_select_b0});
		end
	end

	// ==========================================================
	// Tick selection
	always_comb begin
		tcs_src_t src;
		tcs_chan_cfg_t cfg;
		logic [3:0] idx;
		src = TCS_SRC_DIV1;
		cfg = '0;
		idx = 4'h0;
		tick_nxt = '0;
		for (int ch = 0; ch < `TCS_CHANNELS; ch++) begin
			cfg = chan_cfg[ch];
			src = src_sel[ch];
			idx = tap_index(src);
			case (src)
				TCS_SRC_DIV1: tick_nxt[ch] = 1'b1;
				TCS_SRC_CASCADE: begin
					// Neighbour wrap pulses count directly, edge fields play no part
					tick_nxt[ch] = (ch == 1) ? chan2_counter_wrap : chan5_counter_wrap;
				end
				TCS_SRC_EXT_A, TCS_SRC_EXT_B, TCS_SRC_EXT_C, TCS_SRC_EXT_D: begin
					idx = 4'(src - TCS_SRC_EXT_A);
					tick_nxt[ch] = edge_pick(rise_of(ext_r[idx[1:0]], ext_prev_r[idx[1:0]]),
						fall_of(ext_r[idx[1:0]], ext_prev_r[idx[1:0]]), cfg, 1'b0);
				end
				default: begin
					tick_nxt[ch] = edge_pick(rise_of(div_r[idx], div_prev_r[idx]),
						fall_of(div_r[idx], div_prev_r[idx]), cfg, 1'b1);
				end
			endcase
			// Phase counting owns the counter, so no prescaled tick leaks through
			if (PHASE_CAP[ch] && phase_mode[ch]) begin
				tick_nxt[ch] = 1'b0;
			end
		end
	end

	// ==========================================================
	// Registered ticks, one cycle per count event
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			tick_r <= '0;
		end else begin
			tick_r <= tick_nxt;
		end
	end

	assign count_tick = tick_r;

endmodule

`default_nettype wire

// ---- tcs_clock_select_properties.sv ----
// Assertion checker for the count clock select block
`include "tcs_defines.svh"
`default_nettype none
module tcs_clock_select_properties import tcs_pkg::*; (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire tcs_chan_cfg_t chan_cfg [`TCS_CHANNELS],
	input wire logic [`TCS_CHANNELS-1:0] phase_mode,
	input wire tcs_ext_pins_t ext_pins,
	input wire logic chan2_counter_wrap,
	input wire logic chan5_counter_wrap,
	input wire logic [`TCS_CHANNELS-1:0] count_tick
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	wire logic pin_a = ext_pins.ext_count_in_a;
	// ==========================================================
	// Settings held through the pipe before a tick is judged
	sequence s_div1;
		(chan_cfg[0][2:0] == 3'h0) [*2];
	endsequence
	sequence s_ext;
		(chan_cfg[0][2:0] == 3'h4 && chan_cfg[0] == $past(chan_cfg[0]) && $past(rst_n, 3)) [*3];
	endsequence
	property p_div1;
		s_div1 |=> count_tick[0];
	endproperty
	property p_div3;
		(chan_cfg[3][2:0] == 3'h0) [*2] |=> count_tick[3];
	endproperty
	property p_casc1;
		(chan_cfg[1][2:0] == 3'h7 && !phase_mode[1]) [*3] |-> count_tick[1] == $past(chan2_counter_wrap);
	endproperty
	property p_casc4;
		(chan_cfg[4][2:0] == 3'h7 && !phase_mode[4]) [*3] |-> count_tick[4] == $past(chan5_counter_wrap);
	endproperty
	property p_phase1;
		phase_mode[1] [*2] |=> !count_tick[1];
	endproperty
	property p_phase5;
		phase_mode[5] [*2] |=> !count_tick[5];
	endproperty
	property p_ext;
		s_ext |-> count_tick[0] == ($past(pin_a, 2) != $past(pin_a, 3) &&
			(chan_cfg[0].edge_select_hi || ($past(pin_a, 2) ^ chan_cfg[0].edge_select_lo)));
	endproperty
	// Falling and rising picks of one divider never coincide
	property p_split;
		(chan_cfg[0] == 5'h09 && chan_cfg[3] == 5'h01) [*3] |-> !(count_tick[0] && count_tick[3]);
	endproperty
	a_div1: assert property (p_div1) else $error("no tick on undivided ch0");
	a_div3: assert property (p_div3) else $error("no tick on undivided ch3");
	a_casc1: assert property (p_casc1) else $error("ch1 cascade tick wrong");
	a_casc4: assert property (p_casc4) else $error("ch4 cascade tick wrong");
	a_phase1: assert property (p_phase1) else $error("ch1 ticks in phase mode");
	a_phase5: assert property (p_phase5) else $error("ch5 ticks in phase mode");
	a_ext: assert property (p_ext) else $error("ch0 pin edge tick wrong");
	a_split: assert property (p_split) else $error("edge choice has no effect");
endmodule
bind tcs_clock_select tcs_clock_select_properties u_props (.sys_clk, .rst_n, .chan_cfg, .phase_mode,
	.ext_pins, .chan2_counter_wrap, .chan5_counter_wrap, .count_tick);
`default_nettype wire

// ---- tb_timer_count_clock_select.sv ----
// Self-checking bench for the count clock select block
`include "tcs_defines.svh"
`default_nettype none
module tb_timer_count_clock_select import tcs_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int W = 4096;
	// Source kind per code, one nibble per code, code 7 leftmost
	localparam logic [31:0] SRC_TAB [6] = '{32'ha9873210, 32'hb4873210, 32'h59873210, 32'h64573210,
		32'hb5973210, 32'ha4973210};
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	tcs_chan_cfg_t chan_cfg [`TCS_CHANNELS];
	logic [5:0] phase_mode = 6'h00;
	tcs_ext_pins_t ext_pins = 4'h0;
	logic chan2_counter_wrap = 1'b0;
	logic chan5_counter_wrap = 1'b0;
	logic [5:0] count_tick;
	logic clr = 1'b0;
	int errors = 0;
	int compares = 0;
	int cnt [6];
	int rises [4];
	int falls [4];
	int wraps [2];
	int exp_q [$];
	event win_end;
	always #2 sys_clk = ~sys_clk;
	tcs_clock_select DUT (.sys_clk(sys_clk), .rst_n(rst_n), .chan_cfg(chan_cfg), .phase_mode(phase_mode),
		.ext_pins(ext_pins), .chan2_counter_wrap(chan2_counter_wrap), .chan5_counter_wrap(chan5_counter_wrap),
		.count_tick(count_tick));
	// ==========================================================
	// Tick counts over a whole window, exact for any periodic source
	function automatic int expect_cnt(int ch, int code, int e, logic ph);
		int s;
		s = SRC_TAB[ch][4*code +: 4];
		if (ph && ch % 3 != 0) return 0;
		if (s == 11) return wraps[ch / 4];
		if (s >= 7) return e[1] ? rises[s-7] + falls[s-7] : (e[0] ? falls[s-7] : rises[s-7]);
		if (s == 0) return W;
		return (e[1] ? 2 * W : W) >> (2 * s);
	endfunction
	always @(posedge sys_clk) begin
		if (rst_n && $isunknown(count_tick)) begin
			errors++;
			$display("wrong value at %0t: tick output unknown", $time);
		end
		for (int i = 0; i < 6; i++) begin
			cnt[i] = clr ? 0 : cnt[i] + ((count_tick[i] === 1'b1) ? 1 : 0);
		end
	end
	always @(win_end) begin
		int e;
		for (int i = 0; i < 6; i++) begin
			e = exp_q.pop_front();
			compares++;
			if (cnt[i] != e) begin
				errors++;
				$display("wrong value at %0t: ch %0d ticks %0d expected %0d", $time, i, cnt[i], e);
			end
		end
	end
	task automatic wrap_up();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// ==========================================================
	// Every code on every channel, edges rotated per channel
	initial begin
		logic [3:0] nxt;
		for (int i = 0; i < 6; i++) chan_cfg[i] = 5'h00;
		void'($urandom(39));
		repeat (8) @(posedge sys_clk);
		@(negedge sys_clk) rst_n = 1'b1;
		for (int p = 0; p <= 2; p += 2) begin
			for (int c = 0; c < 8; c++) begin
				@(negedge sys_clk);
				for (int i = 0; i < 6; i++) chan_cfg[i] = tcs_chan_cfg_t'({2'((c + p + i) % 4), 3'(c)});
				phase_mode = p ? (6'($urandom) | (c[0] ? 6'h22 : 6'h14)) : 6'h00;
				repeat (8) @(negedge sys_clk);
				clr = 1'b1;
				rises = '{0, 0, 0, 0};
				falls = '{0, 0, 0, 0};
				wraps = '{0, 0};
				@(negedge sys_clk) clr = 1'b0;
				for (int k = 0; k < W; k++) begin
					// Pin and wrap activity stops early so late ticks still land in the window
					nxt = ext_pins ^ (k < 3000 ? 4'($urandom) & 4'($urandom) : 4'h0);
					for (int j = 0; j < 4; j++) begin
						rises[j] += (!ext_pins[j] && nxt[j]) ? 1 : 0;
						falls[j] += (ext_pins[j] && !nxt[j]) ? 1 : 0;
					end
					ext_pins = nxt;
					chan2_counter_wrap = !chan2_counter_wrap && k < 3000 && $urandom % 5 == 0;
					chan5_counter_wrap = !chan5_counter_wrap && k < 3000 && $urandom % 3 == 0;
					wraps[0] += chan2_counter_wrap;
					wraps[1] += chan5_counter_wrap;
					@(negedge sys_clk);
				end
				for (int i = 0; i < 6; i++) exp_q.push_back(expect_cnt(i, c, (c + p + i) % 4, phase_mode[i]));
				->win_end;
				$display("test code %0d pass %0d done", c, p);
			end
		end
		@(negedge sys_clk);
		wrap_up();
	end
endmodule
`default_nettype wire
